// >>> lsw_timer_defs.svh
/*
  Constants of the long span timer: prescaler sizes, function codes.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef LSW_TIMER_DEFS_SVH
`define LSW_TIMER_DEFS_SVH
`define LSW_CNT_W 24
`define LSW_AR_W 16
`define LSW_PRE1_DIV 16
`define LSW_PRE2_DIV 2048
`define LSW_FUNC_W 3
`define LSW_FN_FLAG 3'h1
`define LSW_FN_SLEEP 3'h2
`define LSW_FN_SLEEP_WAKE 3'h3
`define LSW_FN_WAKE 3'h4
`define LSW_FN_OVF 3'h5
`endif

// >>> lsw_timer_pkg.sv
/*
  Types of the long span timer.
  Assumes lsw_timer_defs.svh is on the include path.
*/
`include "lsw_timer_defs.svh"
package lsw_timer_pkg;
  typedef enum logic [2:0] {
    LSW_IDLE,
    LSW_AFTER_RUN,
    LSW_WAIT_LP,
    LSW_WAKE_RUN,
    LSW_STOPPED
  } lsw_state_t;
endpackage

// >>> lsw_prescaler.sv
/*
  Two-stage prescaler: first stage divides the oscillator tick by DIV1,
  the second by DIV2 unless bypassed for calibration.
  Assumes i_osc_tick is a one-cycle pulse on i_clock.
*/
`timescale 1ns/1ps
`include "lsw_timer_defs.svh"
module lsw_prescaler #(
  parameter int DIV1 = `LSW_PRE1_DIV,
  parameter int DIV2 = `LSW_PRE2_DIV
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_osc_tick,
  input wire logic i_bypass2,
  output logic o_tick
);
  localparam int W1 = $clog2(DIV1);
  localparam int W2 = $clog2(DIV2);
  localparam logic [W1-1:0] LAST1 = W1'(DIV1 - 1);
  localparam logic [W2-1:0] LAST2 = W2'(DIV2 - 1);
  logic [W1-1:0] stage1;
  logic [W2-1:0] stage2;
  wire end1 = i_osc_tick && (stage1 == LAST1);
  wire end2 = end1 && (stage2 == LAST2);
  wire next_tick = i_bypass2 ? end1 : end2;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= next_tick && !i_clear;
      if (i_clear) begin
        stage1 <= '0;
        stage2 <= '0;
      end else begin
        if (i_osc_tick) stage1 <= end1 ? '0 : stage1 + 1'b1;
        if (end1) stage2 <= end2 ? '0 : stage2 + 1'b1;
      end
    end
  end
endmodule

// >>> lsw_timer.sv
/*
  Long span timer: an oscillator-driven 24-bit counter with five
  functions for after-run and wake-up in low-power mode.
  Assumes the power-mode controller acts on the request outputs and
  reports low-power state on i_low_power; the host writes the ports.
*/
`timescale 1ns/1ps
`include "lsw_timer_defs.svh"
module lsw_timer #(
  parameter int CNT_W = `LSW_CNT_W,
  parameter int AR_W = `LSW_AR_W
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_osc_clk,
  input wire logic i_timer_run_enable,
  input wire logic [`LSW_FUNC_W-1:0] i_function,
  input wire logic i_calibration,
  input wire logic [AR_W-1:0] i_after_run_value,
  input wire logic i_after_run_load,
  input wire logic [CNT_W-1:0] i_wake_up_value,
  input wire logic i_wake_up_load,
  input wire logic i_low_power,
  input wire logic i_flag_clear,
  output logic [AR_W-1:0] o_after_run_value,
  output logic [CNT_W-1:0] o_wake_up_value,
  output logic [CNT_W-1:0] o_count,
  output logic o_end_of_count,
  output logic o_count_overflow,
  output logic o_after_run_flag,
  output logic o_low_power_request,
  output logic o_wake_up_request,
  output logic o_running
);
  ////////////////////////////////////////////////////////////////////////
  // Oscillator and low-power input synchronisers
  logic osc_s1, osc_s2, osc_s3;
  logic lp_s1, lp_s2;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      lp_s1 <= 1'b0;
      lp_s2 <= 1'b0;
    end else begin
      osc_s1 <= i_osc_clk;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      lp_s1 <= i_low_power;
      lp_s2 <= lp_s1;
    end
  end
  // Rising edge of the 32768 Hz oscillator, one cycle per period
  wire osc_tick = osc_s2 && !osc_s3;
  wire low_power = lp_s2;

  ////////////////////////////////////////////////////////////////////////
  // Compare values, held and read back by the host
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_after_run_value <= '0;
      o_wake_up_value <= '0;
    end else begin
      if (i_after_run_load) o_after_run_value <= i_after_run_value;
      if (i_wake_up_load) o_wake_up_value <= i_wake_up_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Function decode
  lsw_timer_pkg::lsw_state_t state, next_state;
  wire fn_flag = i_function == `LSW_FN_FLAG;
  wire fn_sleep = i_function == `LSW_FN_SLEEP;
  wire fn_sw = i_function == `LSW_FN_SLEEP_WAKE;
  wire fn_wake = i_function == `LSW_FN_WAKE;
  wire fn_ovf = i_function == `LSW_FN_OVF;
  wire fn_after_run = fn_flag || fn_sleep || fn_sw;
  wire fn_lp = fn_wake || fn_ovf;

  logic [CNT_W-1:0] count;
  logic pre_tick;
  wire counting = (state == lsw_timer_pkg::LSW_AFTER_RUN) ||
                  (state == lsw_timer_pkg::LSW_WAKE_RUN);
  // Dropping enable zeroes the count at once, not a cycle after idle
  wire restart = state == lsw_timer_pkg::LSW_IDLE ||
                 state == lsw_timer_pkg::LSW_WAIT_LP ||
                 !i_timer_run_enable;

  // Calibration skips the second stage; prescaler is held clear off-run
  lsw_prescaler #(
    .DIV1(`LSW_PRE1_DIV),
    .DIV2(`LSW_PRE2_DIV)
  ) u_prescaler (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clear(!counting),
    .i_osc_tick(osc_tick),
    .i_bypass2(i_calibration),
    .o_tick(pre_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // End-of-count detection by equality
  wire [CNT_W-1:0] ar_ext = {{(CNT_W-AR_W){1'b0}}, o_after_run_value};
  wire ar_hit = count == ar_ext;
  wire wu_hit = count == o_wake_up_value;
  wire ovf_hit = &count;
  wire in_ar = state == lsw_timer_pkg::LSW_AFTER_RUN;
  wire in_wu = state == lsw_timer_pkg::LSW_WAKE_RUN;
  wire ar_end = in_ar && ar_hit;
  wire wu_end = in_wu && (fn_ovf ? ovf_hit : wu_hit);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer; clearing enable always returns to idle
  always_comb begin
    next_state = state;
    case (state)
      lsw_timer_pkg::LSW_IDLE: begin
        if (i_timer_run_enable) begin
          if (fn_after_run) next_state = lsw_timer_pkg::LSW_AFTER_RUN;
          else if (fn_lp) next_state = lsw_timer_pkg::LSW_WAIT_LP;
        end
      end
      lsw_timer_pkg::LSW_AFTER_RUN: begin
        if (ar_end) begin
          if (fn_sw) next_state = lsw_timer_pkg::LSW_WAIT_LP;
          else next_state = lsw_timer_pkg::LSW_STOPPED;
        end
      end
      lsw_timer_pkg::LSW_WAIT_LP: begin
        // Wake-up count starts on entering low power
        if (low_power) next_state = lsw_timer_pkg::LSW_WAKE_RUN;
      end
      lsw_timer_pkg::LSW_WAKE_RUN: begin
        // Function 4 counts only while asleep; function 5 keeps on
        // through a wake-up from another source
        if (wu_end) next_state = lsw_timer_pkg::LSW_STOPPED;
      end
      lsw_timer_pkg::LSW_STOPPED: next_state = state;
      default: next_state = lsw_timer_pkg::LSW_IDLE;
    endcase
    if (!i_timer_run_enable) next_state = lsw_timer_pkg::LSW_IDLE;
  end

  // Function 4 pauses while awake; other wake functions run regardless
  wire step = pre_tick && !ar_end && !wu_end &&
              !(in_wu && fn_wake && !low_power);
  wire [CNT_W-1:0] next_count = restart ? '0 :
                                step ? count + 1'b1 : count;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= lsw_timer_pkg::LSW_IDLE;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Requests and status; a new end event wins over a host clear
  logic ar_flag, lp_req, wu_req, eoc, ovf;
  wire set_ovf = wu_end && fn_ovf;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ar_flag <= 1'b0;
      lp_req <= 1'b0;
      wu_req <= 1'b0;
      eoc <= 1'b0;
      ovf <= 1'b0;
      o_count <= '0;
    end else begin
      ar_flag <= (ar_end && fn_flag) || (ar_flag && !i_flag_clear);
      lp_req <= (ar_end && !fn_flag) ||
                (lp_req && !i_flag_clear);
      wu_req <= wu_end || (wu_req && !i_flag_clear);
      eoc <= ar_end || wu_end || (eoc && !i_flag_clear);
      ovf <= set_ovf || (ovf && !i_flag_clear);
      o_count <= next_count;
    end
  end
  assign o_after_run_flag = ar_flag;
  assign o_low_power_request = lp_req;
  assign o_wake_up_request = wu_req;
  assign o_end_of_count = eoc;
  assign o_count_overflow = ovf;
  assign o_running = counting;
endmodule

// >>> lsw_power_model.sv
/* Far-side model: oscillator and power-mode controller.
   Assumes the bench drives i_sleep and i_other_wake on i_clock. */
`timescale 1ns/1ps
module lsw_power_model #(
  parameter int HALF = 60
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_lp_req,
  input wire logic i_wake_req,
  input wire logic i_sleep,
  input wire logic i_other_wake,
  output logic o_osc_clk,
  output logic o_low_power
);
  // Fast oscillator keeps runs short; only the divide ratios matter
  logic osc = 1'b0;
  always #(HALF) osc = ~osc;
  assign o_osc_clk = osc;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n)
      o_low_power <= 1'b0;
    else if (i_wake_req || i_other_wake)
      o_low_power <= 1'b0;
    else if (i_lp_req || i_sleep)
      o_low_power <= 1'b1;
  end
endmodule

// >>> lsw_timer_props.sv
/* Port checker of the long span timer.
   Assumes it is bound to lsw_timer with the same widths. */
`timescale 1ns/1ps
module lsw_timer_props #(
  parameter int CNT_W = 24,
  parameter int AR_W = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_timer_run_enable,
  input wire logic i_flag_clear,
  input wire logic i_after_run_load,
  input wire logic [AR_W-1:0] i_after_run_value,
  input wire logic [AR_W-1:0] o_after_run_value,
  input wire logic [CNT_W-1:0] o_count,
  input wire logic [CNT_W-1:0] o_wake_up_value,
  input wire logic o_end_of_count,
  input wire logic o_count_overflow,
  input wire logic o_after_run_flag,
  input wire logic o_wake_up_request,
  input wire logic o_running
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  chk_ar_readback: assert property (
    i_after_run_load |=> o_after_run_value == $past(i_after_run_value))
    else $error("after-run readback wrong");
  chk_count_step: assert property (
    !$stable(o_count) |-> o_count == $past(o_count) + 1'b1 || o_count == '0)
    else $error("count moved by other than one");
  chk_idle_zero: assert property (
    $fell(i_timer_run_enable) |=> o_count == '0)
    else $error("count not cleared when disabled");
  chk_stop_holds: assert property (
    (o_after_run_flag || o_wake_up_request) && i_timer_run_enable
    ##1 i_timer_run_enable |-> $stable(o_count))
    else $error("count moved after its end");
  chk_ovf_value: assert property (
    $rose(o_count_overflow) |-> &o_count)
    else $error("overflow below full count");
  chk_ar_match: assert property (
    $rose(o_after_run_flag) |-> o_count == CNT_W'(o_after_run_value))
    else $error("after-run flag off its value");
  chk_wake_match: assert property (
    $rose(o_wake_up_request) && !o_count_overflow
    |-> o_count == o_wake_up_value)
    else $error("wake-up off its value");
  chk_flag_clear: assert property (
    i_flag_clear && !o_running |=> !(o_after_run_flag || o_end_of_count))
    else $error("flags survive a clear");
endmodule
bind lsw_timer lsw_timer_props #(.CNT_W(CNT_W), .AR_W(AR_W)) u_props (
  .i_clock, .i_rst_n, .i_timer_run_enable, .i_flag_clear,
  .i_after_run_load, .i_after_run_value, .o_after_run_value, .o_count,
  .o_wake_up_value, .o_end_of_count, .o_count_overflow, .o_after_run_flag,
  .o_wake_up_request, .o_running);

// >>> test_long_duration_wakeup_timer.sv
/* Bench of the long span timer with a power-mode model.
   Assumes a short counter width so overflow is reachable. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module test_long_duration_wakeup_timer;
  localparam int CW = 8;
  localparam int AW = 6;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic en = 1'b0, cal = 1'b0, arl = 1'b0, wul = 1'b0, fc = 1'b0;
  logic sleep = 1'b0, owake = 1'b0;
  logic [2:0] fn = 3'h0;
  logic [AW-1:0] arv = '0;
  logic [CW-1:0] wuv = '0;
  wire osc, lp, eoc, ovf, arf, lpr, wur, run;
  wire [AW-1:0] ar_rb;
  wire [CW-1:0] wu_rb, cnt;
  int failures = 0;
  int tests_run = 0;
  always #10 i_clock = ~i_clock;
  lsw_timer #(.CNT_W(CW), .AR_W(AW)) uut (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_osc_clk(osc), .i_timer_run_enable(en),
    .i_function(fn), .i_calibration(cal), .i_after_run_value(arv),
    .i_after_run_load(arl), .i_wake_up_value(wuv), .i_wake_up_load(wul),
    .i_low_power(lp), .i_flag_clear(fc), .o_after_run_value(ar_rb),
    .o_wake_up_value(wu_rb), .o_count(cnt), .o_end_of_count(eoc),
    .o_count_overflow(ovf), .o_after_run_flag(arf),
    .o_low_power_request(lpr), .o_wake_up_request(wur), .o_running(run));
  lsw_power_model u_power (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_lp_req(lpr), .i_wake_req(wur), .i_sleep(sleep),
    .i_other_wake(owake), .o_osc_clk(osc), .o_low_power(lp));
  ////////////////////////////////////////////////////////////////////////
  // Clears flags and wakes the device before each restart
  task automatic start(input logic [2:0] f, input logic c,
                       input logic [AW-1:0] a, input logic [CW-1:0] w);
    @(posedge i_clock);
    {en, fc, owake, sleep, arl, wul} <= 6'h1b;
    {fn, cal, arv, wuv} <= {f, c, a, w};
    @(posedge i_clock);
    {en, fc, owake, arl, wul} <= 5'h10;
  endtask
  task automatic wait_ev(input logic wake);
    for (int k = 0; k < 30000; k++) begin
      @(negedge i_clock);
      if (wake ? wur : (eoc || ovf))
        break;
    end
    // A run that never ends counts as a mismatch here
    `CHK("event seen", 1'b1, wake ? wur : (eoc || ovf))
  endtask
  task automatic t_prescale;
    start(3'h1, 1'b1, 6'h3f, 8'h00);
    repeat (970) @(negedge i_clock);
    `CHK("cal", 1'b1, cnt>=8'h09 && cnt<=8'h0a)
    `CHK("running", 1'b1, run)
    start(3'h1, 1'b0, 6'h01, 8'h00);
    repeat (970) @(negedge i_clock);
    `CHK("normal count", 8'h00, cnt)
    start(3'h0, 1'b1, 6'h01, 8'h00);
    repeat (300) @(negedge i_clock);
    `CHK("bad function", 1'b0, run)
  endtask
  task automatic t_flag;
    start(3'h1, 1'b1, 6'h03, 8'h5a);
    wait_ev(1'b0);
    `CHK("flag", 1'b1, arf)
    `CHK("end of count", 1'b1, eoc)
    `CHK("count", 8'h03, cnt)
    `CHK("ar readback", 6'h03, ar_rb)
    `CHK("wu readback", 8'h5a, wu_rb)
    `CHK("no lp req", 1'b0, lpr)
    repeat (300) @(negedge i_clock);
    `CHK("held", 8'h03, cnt)
  endtask
  task automatic t_sleep;
    start(3'h2, 1'b1, 6'h02, 8'h00);
    wait_ev(1'b0);
    `CHK("lp req", 1'b1, lpr)
    `CHK("count", 8'h02, cnt)
    start(3'h3, 1'b1, 6'h02, 8'h03);
    wait_ev(1'b1);
    `CHK("wake", 1'b1, wur)
    `CHK("lp req 3", 1'b1, lpr)
    `CHK("wake count", 8'h03, cnt)
  endtask
  task automatic t_wake;
    logic [CW-1:0] c0;
    start(3'h4, 1'b1, 6'h00, 8'h02);
    repeat (300) @(negedge i_clock);
    `CHK("awake pause", 8'h00, cnt)
    @(posedge i_clock);
    sleep <= 1'b1;
    wait_ev(1'b1);
    `CHK("wake count", 8'h02, cnt)
    start(3'h5, 1'b1, 6'h00, 8'h00);
    sleep <= 1'b1;
    repeat (500) @(posedge i_clock);
    {sleep, owake} <= 2'h1;
    @(posedge i_clock);
    owake <= 1'b0;
    // Sample away from the edge that launches the count
    @(negedge i_clock);
    c0 = cnt;
    repeat (300) @(negedge i_clock);
    `CHK("other wake", 1'b1, cnt > c0 && !wur)
    wait_ev(1'b0);
    `CHK("overflow", 1'b1, ovf)
    `CHK("full", 8'hff, cnt)
    `CHK("ovf wake", 1'b1, wur)
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_prescale;
    t_flag;
    t_sleep;
    t_wake;
    tally_and_finish;
  end
  // Whole plan needs about 29k cycles
  initial begin
    #2000000;
    failures++;
    tally_and_finish;
  end
endmodule
